// ==== rtl/lmsc_regs.vh ====
// Summary of operation
// (RULE1) Second mode strap level n sets external control, cable, remote ID load to n-1.
// (RULE2) Display ID select strap value latched into bridge_control bit 0.
// (RULE3) Auxiliary audio strap value latched into bridge_configuration bit 1.
// (RULE4) External controller override strap latched into bridge_configuration bit 7.
// (RULE5) Cable type strap latched into dual_link_control bit 7; one means cable_type_select.
// (RULE6) Remote display ID load strap latched into bridge_configuration bit 5.
// (RULE7) Single link sends all video on one downlink, up to 96 MHz.
// (RULE8) Older receivers are supported in single link only below 85 MHz.
// (RULE9) Forced single mode disables secondary transmit PHY and its back channel.
// (RULE10) Dual link splits the stream into alternating pixels on both links.
// (RULE11) Dual link with protection uses one shared protection session.
// (RULE12) Dual link accepts up to 170 MHz, each port at half rate.
// (RULE13) Dual link is entered automatically with capable receiver and enough frequency, or forced.
// (RULE14) Replicate mode is a 1:2 repeater with a second protection core, up to 85 MHz.
// (RULE15) Receiver capabilities and pixel clock frequency together choose the link mode.
// (RULE16) Two independent single receivers give replicate mode.
// (RULE17) Receiver only on secondary link sends video on secondary alone.
// (RULE18) A dual_link_control bit disables auto-detection so forced mode applies.
// (RULE19) While enabled, a detected frequency change resets the link PLL.
// (RULE20) Software clears dual_link_control bit 5 after configuring both ends.
// (RULE21) Address strap selects one of eight control bus target addresses.
// (RULE22) Control bus lines are only driven low or released, never driven high.
// (RULE23) Mode straps are sampled once after power-up and latched into registers.
// (RULE24) First mode strap level n sets display ID select and auxiliary audio to n-1.
// (RULE25) Address levels map upward to 7-bit addresses 0x0c to 0x1a step two.
// (RULE26) Software writes replace strap values and steer mode selection afterwards.
// (RULE27) With auto-detection off, the forced setting alone selects the link mode.
`ifndef LMSC_REGS_VH
`define LMSC_REGS_VH
// Register offsets
`define LMSC_OFF_BRIDGE_CONTROL 8'h4f
`define LMSC_OFF_BRIDGE_CFG 8'h54
`define LMSC_OFF_DUAL_CTL 8'h5b
`define LMSC_OFF_LINK_STAT 8'h5c
// Field positions
`define LMSC_BIT_DISP_ID_SEL 0
`define LMSC_BIT_AUX_AUDIO 1
`define LMSC_BIT_REM_ID_LOAD 5
`define LMSC_BIT_EXTERNAL_CONTROLLER_OVERRIDE 7
`define LMSC_BIT_CABLE 7
`define LMSC_BIT_PLL_RST_EN 5
`define LMSC_BIT_AUTO_DIS 4
// Reset values
`define LMSC_RST_BRIDGE_CONTROL 8'h00
`define LMSC_RST_BRIDGE_CFG 8'h00
`define LMSC_RST_DUAL_CTL 8'h20
// Link mode codes
`define LMSC_MODE_SINGLE 2'h0
`define LMSC_MODE_FSINGLE 2'h1
`define LMSC_MODE_DUAL 2'h2
`define LMSC_MODE_REPL 2'h3
// Frequency limits in MHz
`define LMSC_SINGLE_MAX_MHZ 8'h60
`define LMSC_LEGACY_LIM_MHZ 8'h55
`define LMSC_DUAL_MAX_MHZ 8'haa
`define LMSC_REPL_MAX_MHZ 8'h55
// Control bus address table base
`define LMSC_ADDR_BASE 7'h0c
`endif

// ==== rtl/lmsc_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "lmsc_regs.vh"

module lmsc_top #(
    parameter [7:0] DUAL_MIN_MHZ = 8'h61,
    parameter [7:0] FREQ_TOL_MHZ = 8'h02
) (
    // Clock and reset
    input wire i_clock,
    input wire i_resetn,
    // Strap levels, as level index minus one
    input wire [1:0] i_first_mode_strap,
    input wire [2:0] i_second_mode_strap,
    input wire [2:0] i_address_strap,
    // Control bus pins
    input wire i_scl_in,
    output reg o_scl_out,
    output reg o_scl_oe,
    input wire i_sda_in,
    output reg o_sda_out,
    output reg o_sda_oe,
    // Downstream detection and frequency
    input wire i_rx_primary_present,
    input wire i_rx_secondary_present,
    input wire i_rx_dual_capable,
    input wire i_rx_legacy,
    input wire [7:0] i_pclk_mhz,
    // Link control outputs
    output reg [1:0] o_link_mode,
    output reg o_primary_tx_en,
    output reg o_secondary_tx_en,
    output reg o_secondary_bc_en,
    output reg o_pixel_split,
    output reg o_tx_half_rate,
    output reg o_shared_prot_session,
    output reg o_second_prot_core_en,
    output reg o_rate_ok,
    output reg o_pll_reset,
    // Strapped configuration outputs
    output reg o_display_id_select,
    output reg o_aux_audio,
    output reg o_external_control_bit,
    output reg o_cable_type_bit,
    output reg o_remote_display_id_load,
    output reg [6:0] o_bus_address
);

    ////////////////////////////////////////////////////////////////////////
    // Bus states, one-hot
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_ACKA = 7'h04;
    localparam [6:0] ST_WR = 7'h08;
    localparam [6:0] ST_ACKW = 7'h10;
    localparam [6:0] ST_RD = 7'h20;
    localparam [6:0] ST_ACKR = 7'h40;

    reg [7:0] bridge_control_r;
    reg [7:0] bridge_configuration_r;
    reg [7:0] dual_link_control_r;
    reg strap_done_r;
    reg secondary_only_r;
    reg [7:0] freq_prev_r;
    reg [6:0] state_r;
    reg scl_r;
    reg sda_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg [3:0] cnt_r;
    reg [7:0] ptr_r;
    reg rw_r;
    reg first_r;
    reg mack_r;
    reg wr_en_r;
    reg [7:0] wr_ptr_r;
    reg [7:0] wr_data_r;
    reg [1:0] mode_nxt;
    reg sec_only_nxt;
    reg rate_ok_nxt;
    wire start_det;
    wire stop_det;
    wire scl_rise;
    wire scl_fall;
    wire [7:0] link_stat;
    wire freq_change;

    ////////////////////////////////////////////////////////////////////////
    // Register read mux
    function [7:0] reg_read;
        input [7:0] addr;
        begin
            if (addr == `LMSC_OFF_BRIDGE_CONTROL) begin
                reg_read = bridge_control_r;
            end else if (addr == `LMSC_OFF_BRIDGE_CFG) begin
                reg_read = bridge_configuration_r;
            end else if (addr == `LMSC_OFF_DUAL_CTL) begin
                reg_read = dual_link_control_r;
            end else if (addr == `LMSC_OFF_LINK_STAT) begin
                reg_read = link_stat;
            end else begin
                reg_read = 8'h00;
            end
        end
    endfunction

    // Absolute difference of two frequency readings
    function [7:0] abs_diff;
        input [7:0] a;
        input [7:0] b;
        begin
            abs_diff = (a > b) ? (a - b) : (b - a);
        end
    endfunction

    // Top bit of a register, sent first on a read
    function reg_msb;
        input [7:0] addr;
        reg [7:0] v;
        begin
            v = reg_read(addr);
            reg_msb = v[7];
        end
    endfunction

    // Status word shows the block's own state together with the receiver detection inputs except i_rx_legacy
    assign link_stat = {strap_done_r, i_rx_dual_capable, i_rx_secondary_present, i_rx_primary_present,
                        o_rate_ok, secondary_only_r, o_link_mode};

    ////////////////////////////////////////////////////////////////////////
    // Bus condition detection
    assign start_det = i_scl_in & scl_r & sda_r & ~i_sda_in;
    assign stop_det = i_scl_in & scl_r & ~sda_r & i_sda_in;
    assign scl_rise = i_scl_in & ~scl_r;
    assign scl_fall = ~i_scl_in & scl_r;

    // Bus slave, drives lines low only
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            state_r <= ST_IDLE;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            cnt_r <= 4'h0;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            mack_r <= 1'b0;
            wr_en_r <= 1'b0;
            wr_ptr_r <= 8'h00;
            wr_data_r <= 8'h00;
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0; // RULE22
            o_scl_out <= 1'b0; // RULE22
            o_scl_oe <= 1'b0;
        end else begin
            wr_en_r <= 1'b0;
            scl_r <= i_scl_in;
            sda_r <= i_sda_in;
            if (start_det) begin
                state_r <= ST_ADDR;
                cnt_r <= 4'h0;
                first_r <= 1'b1;
                o_sda_oe <= 1'b0;
            end else if (stop_det) begin
                state_r <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (state_r == ST_ACKR) begin
                    mack_r <= i_sda_in;
                end else if (state_r != ST_IDLE) begin
                    shift_r <= {shift_r[6:0], i_sda_in};
                    cnt_r <= cnt_r + 4'h1;
                end
            end else if (scl_fall) begin
                case (state_r)
                    ST_ADDR: begin
                        if (cnt_r == 4'h8) begin
                            if (shift_r[7:1] == o_bus_address) begin
                                state_r <= ST_ACKA;
                                rw_r <= shift_r[0];
                                o_sda_oe <= 1'b1; // RULE22
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACKA: begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            state_r <= ST_RD;
                            tx_r <= reg_read(ptr_r);
                            o_sda_oe <= ~reg_msb(ptr_r);
                        end else begin
                            state_r <= ST_WR;
                            o_sda_oe <= 1'b0;
                        end
                    end
                    ST_WR: begin
                        if (cnt_r == 4'h8) begin
                            if (first_r) begin
                                ptr_r <= shift_r;
                                first_r <= 1'b0;
                            end else begin
                                wr_en_r <= 1'b1;
                                wr_ptr_r <= ptr_r;
                                wr_data_r <= shift_r;
                                ptr_r <= ptr_r + 8'h01;
                            end
                            state_r <= ST_ACKW;
                            o_sda_oe <= 1'b1;
                        end
                    end
                    ST_ACKW: begin
                        cnt_r <= 4'h0;
                        state_r <= ST_WR;
                        o_sda_oe <= 1'b0;
                    end
                    ST_RD: begin
                        if (cnt_r == 4'h8) begin
                            state_r <= ST_ACKR;
                            o_sda_oe <= 1'b0;
                        end else begin
                            o_sda_oe <= ~tx_r[3'h7 - cnt_r[2:0]]; // RULE22
                        end
                    end
                    ST_ACKR: begin
                        if (mack_r) begin
                            state_r <= ST_IDLE;
                        end else begin
                            state_r <= ST_RD;
                            cnt_r <= 4'h0;
                            ptr_r <= ptr_r + 8'h01;
                            tx_r <= reg_read(ptr_r + 8'h01);
                            o_sda_oe <= ~reg_msb(ptr_r + 8'h01);
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers: strap latch once, then software writes
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            bridge_control_r <= `LMSC_RST_BRIDGE_CONTROL;
            bridge_configuration_r <= `LMSC_RST_BRIDGE_CFG;
            dual_link_control_r <= `LMSC_RST_DUAL_CTL;
            strap_done_r <= 1'b0;
            o_bus_address <= `LMSC_ADDR_BASE;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1; // RULE23
            bridge_control_r[`LMSC_BIT_DISP_ID_SEL] <= i_first_mode_strap[1]; // RULE2 RULE24
            bridge_configuration_r[`LMSC_BIT_AUX_AUDIO] <= i_first_mode_strap[0]; // RULE3 RULE24
            bridge_configuration_r[`LMSC_BIT_EXTERNAL_CONTROLLER_OVERRIDE] <= i_second_mode_strap[2]; // RULE4 RULE1
            dual_link_control_r[`LMSC_BIT_CABLE] <= i_second_mode_strap[1]; // RULE5 RULE1
            bridge_configuration_r[`LMSC_BIT_REM_ID_LOAD] <= i_second_mode_strap[0]; // RULE6 RULE1
            o_bus_address <= `LMSC_ADDR_BASE + {3'h0, i_address_strap, 1'b0}; // RULE21 RULE25
        end else if (wr_en_r) begin
            if (wr_ptr_r == `LMSC_OFF_BRIDGE_CONTROL) begin
                bridge_control_r <= wr_data_r; // RULE26
            end else if (wr_ptr_r == `LMSC_OFF_BRIDGE_CFG) begin
                bridge_configuration_r <= wr_data_r; // RULE26
            end else if (wr_ptr_r == `LMSC_OFF_DUAL_CTL) begin
                dual_link_control_r <= wr_data_r; // RULE26 RULE20
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link mode choice from detection, frequency and forced setting
    always @* begin
        sec_only_nxt = 1'b0;
        if (dual_link_control_r[`LMSC_BIT_AUTO_DIS]) begin
            mode_nxt = dual_link_control_r[1:0]; // RULE18 RULE27
        end else if (i_rx_primary_present && i_rx_secondary_present && !i_rx_dual_capable) begin
            mode_nxt = `LMSC_MODE_REPL; // RULE16 RULE15
        end else if (i_rx_primary_present && i_rx_dual_capable && i_pclk_mhz >= DUAL_MIN_MHZ) begin
            mode_nxt = `LMSC_MODE_DUAL; // RULE13 RULE15
        end else begin
            mode_nxt = `LMSC_MODE_SINGLE; // RULE7
            sec_only_nxt = i_rx_secondary_present & ~i_rx_primary_present; // RULE17
        end
        case (mode_nxt)
            `LMSC_MODE_DUAL: rate_ok_nxt = (i_pclk_mhz <= `LMSC_DUAL_MAX_MHZ); // RULE12
            `LMSC_MODE_REPL: rate_ok_nxt = (i_pclk_mhz <= `LMSC_REPL_MAX_MHZ); // RULE14
            default: begin
                if (i_rx_legacy) begin
                    rate_ok_nxt = (i_pclk_mhz < `LMSC_LEGACY_LIM_MHZ); // RULE8
                end else begin
                    rate_ok_nxt = (i_pclk_mhz <= `LMSC_SINGLE_MAX_MHZ); // RULE7
                end
            end
        endcase
    end

    // Frequency change judged beyond the tolerance band
    assign freq_change = abs_diff(i_pclk_mhz, freq_prev_r) > FREQ_TOL_MHZ;

    ////////////////////////////////////////////////////////////////////////
    // Registered link control outputs
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            o_link_mode <= `LMSC_MODE_SINGLE;
            secondary_only_r <= 1'b0;
            o_primary_tx_en <= 1'b0;
            o_secondary_tx_en <= 1'b0;
            o_secondary_bc_en <= 1'b0;
            o_pixel_split <= 1'b0;
            o_tx_half_rate <= 1'b0;
            o_shared_prot_session <= 1'b0;
            o_second_prot_core_en <= 1'b0;
            o_rate_ok <= 1'b0;
            o_pll_reset <= 1'b0;
            freq_prev_r <= 8'h00;
            o_display_id_select <= 1'b0;
            o_aux_audio <= 1'b0;
            o_external_control_bit <= 1'b0;
            o_cable_type_bit <= 1'b0;
            o_remote_display_id_load <= 1'b0;
        end else begin
            o_link_mode <= mode_nxt;
            secondary_only_r <= sec_only_nxt;
            o_rate_ok <= rate_ok_nxt;
            o_primary_tx_en <= ~sec_only_nxt; // RULE17
            o_secondary_tx_en <= (mode_nxt != `LMSC_MODE_FSINGLE); // RULE9
            o_secondary_bc_en <= (mode_nxt != `LMSC_MODE_FSINGLE); // RULE9
            o_pixel_split <= (mode_nxt == `LMSC_MODE_DUAL); // RULE10
            o_tx_half_rate <= (mode_nxt == `LMSC_MODE_DUAL); // RULE12
            o_shared_prot_session <= (mode_nxt == `LMSC_MODE_DUAL); // RULE11
            o_second_prot_core_en <= (mode_nxt == `LMSC_MODE_REPL); // RULE14
            freq_prev_r <= i_pclk_mhz;
            o_pll_reset <= freq_change & dual_link_control_r[`LMSC_BIT_PLL_RST_EN]; // RULE19
            o_display_id_select <= bridge_control_r[`LMSC_BIT_DISP_ID_SEL];
            o_aux_audio <= bridge_configuration_r[`LMSC_BIT_AUX_AUDIO];
            o_external_control_bit <= bridge_configuration_r[`LMSC_BIT_EXTERNAL_CONTROLLER_OVERRIDE];
            o_cable_type_bit <= dual_link_control_r[`LMSC_BIT_CABLE]; // RULE5
            o_remote_display_id_load <= bridge_configuration_r[`LMSC_BIT_REM_ID_LOAD];
        end
    end

endmodule // lmsc_top
`default_nettype wire

// ==== verif/lmsc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module lmsc_checker #(
    parameter [7:0] FREQ_TOL_MHZ = 8'h02
) (
    // Clock and reset
    input wire i_clock,
    input wire i_resetn,
    // Observed ports
    input wire [1:0] i_first_mode_strap,
    input wire [2:0] i_second_mode_strap,
    input wire [2:0] i_address_strap,
    input wire [7:0] i_pclk_mhz,
    input wire o_scl_oe,
    input wire o_sda_out,
    input wire o_sda_oe,
    input wire [1:0] o_link_mode,
    input wire o_primary_tx_en,
    input wire o_secondary_tx_en,
    input wire o_secondary_bc_en,
    input wire o_pixel_split,
    input wire o_second_prot_core_en,
    input wire o_pll_reset,
    input wire o_display_id_select,
    input wire o_aux_audio,
    input wire o_external_control_bit,
    input wire o_cable_type_bit,
    input wire o_remote_display_id_load,
    input wire [6:0] o_bus_address
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    logic [7:0] pclk_q;
    logic [3:0] since_jump;
    ////////////////////////////////////////////////////////////////
    // Cycles since the last frequency step or reset
    always_ff @(posedge i_clock) begin
        pclk_q <= i_pclk_mhz;
        if (!i_resetn || ({1'b0, i_pclk_mhz} >= {1'b0, pclk_q} + {1'b0, FREQ_TOL_MHZ})
            || ({1'b0, pclk_q} >= {1'b0, i_pclk_mhz} + {1'b0, FREQ_TOL_MHZ})) begin
            since_jump <= 4'h0;
        end else if (since_jump != 4'hf) begin
            since_jump <= since_jump + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence s_release;
        $rose(i_resetn);
    endsequence
    chk_scl_never_driven: assert property (!o_scl_oe)
        else $error("clock line driven");
    chk_sda_low_only: assert property (o_sda_oe |-> !o_sda_out)
        else $error("data line driven high");
    chk_first_strap: assert property (
        s_release |=> ##1 ({o_display_id_select, o_aux_audio} == $past(i_first_mode_strap, 2)))
        else $error("first strap decode wrong");
    chk_second_strap: assert property (
        s_release |=> ##1 ({o_external_control_bit, o_cable_type_bit, o_remote_display_id_load}
        == $past(i_second_mode_strap, 2)))
        else $error("second strap decode wrong");
    chk_addr_table: assert property (
        s_release |=> ##1 (o_bus_address == 7'h0c + {$past(i_address_strap, 2), 1'b0}))
        else $error("bus address wrong");
    chk_addr_hold: assert property ($past(i_resetn, 3) |-> $stable(o_bus_address))
        else $error("bus address changed");
    chk_forced_single: assert property (
        (o_link_mode == 2'h1) |-> (!o_secondary_tx_en && !o_secondary_bc_en))
        else $error("secondary link on in forced single");
    chk_dual_split: assert property (o_pixel_split == (o_link_mode == 2'h2))
        else $error("pixel split mismatch");
    chk_repl_core: assert property (o_second_prot_core_en == (o_link_mode == 2'h3))
        else $error("second core mismatch");
    chk_primary_off: assert property (!o_primary_tx_en |-> (o_link_mode == 2'h0))
        else $error("primary off outside single");
    chk_pll_cause: assert property (o_pll_reset |-> (since_jump <= 4'h3))
        else $error("pll reset without frequency step");
endmodule // lmsc_checker
bind lmsc_top lmsc_checker #(.FREQ_TOL_MHZ(FREQ_TOL_MHZ)) u_chk (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_first_mode_strap(i_first_mode_strap), .i_second_mode_strap(i_second_mode_strap),
    .i_address_strap(i_address_strap), .i_pclk_mhz(i_pclk_mhz), .o_scl_oe(o_scl_oe),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_link_mode(o_link_mode), .o_primary_tx_en(o_primary_tx_en),
    .o_secondary_tx_en(o_secondary_tx_en), .o_secondary_bc_en(o_secondary_bc_en),
    .o_pixel_split(o_pixel_split), .o_second_prot_core_en(o_second_prot_core_en), .o_pll_reset(o_pll_reset),
    .o_display_id_select(o_display_id_select), .o_aux_audio(o_aux_audio),
    .o_external_control_bit(o_external_control_bit), .o_cable_type_bit(o_cable_type_bit),
    .o_remote_display_id_load(o_remote_display_id_load), .o_bus_address(o_bus_address));
`default_nettype wire

// ==== verif/lmsc_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lmsc_rx_model (
    // Scene select
    input wire logic [1:0] i_scene,
    // Detection levels and measured clock
    output logic o_primary,
    output logic o_secondary,
    output logic o_dual,
    output logic o_legacy,
    output logic [7:0] o_pclk
);
    // Downstream population and pixel clock per scene
    always_comb begin
        case (i_scene)
            2'h0: {o_primary, o_secondary, o_dual, o_legacy, o_pclk} = {4'hc, 8'h3c};
            2'h1: {o_primary, o_secondary, o_dual, o_legacy, o_pclk} = {4'ha, 8'h78};
            2'h2: {o_primary, o_secondary, o_dual, o_legacy, o_pclk} = {4'ha, 8'h32};
            default: {o_primary, o_secondary, o_dual, o_legacy, o_pclk} = {4'h4, 8'h32};
        endcase
    end
endmodule // lmsc_rx_model
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic [1:0] st1 = 2'h2;
    logic [2:0] st2 = 3'h5;
    logic [2:0] sta = 3'h3;
    logic scl_m = 1'b1;
    logic sda_m = 1'b1;
    logic [1:0] scene = 2'h0;
    logic prim, sec, dcap, leg, scl_o, scl_oe, sda_o, sda_oe, pll, pri_en, sec_en, bc_en, split, half;
    logic shared, core2, rate_ok, dsel, aux, ext, cable, rem, ack, seen;
    logic [7:0] pclk, rdat;
    logic [1:0] mode;
    logic [6:0] baddr;
    logic [1:0] em [4] = '{2'h3, 2'h2, 2'h0, 2'h0};
    logic ep [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic epl [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    int bad_count = 0;
    int comparisons = 0;
    wire scl_line = scl_m & ~scl_oe;
    wire sda_line = sda_m & ~sda_oe;
    ////////////////////////////////////////////////////////////////
    // Clock
    always #20 i_clock = ~i_clock;
    lmsc_rx_model u_rx (.i_scene(scene), .o_primary(prim), .o_secondary(sec), .o_dual(dcap), .o_legacy(leg),
        .o_pclk(pclk));
    lmsc_top u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_first_mode_strap(st1),
        .i_second_mode_strap(st2), .i_address_strap(sta), .i_scl_in(scl_line), .o_scl_out(scl_o),
        .o_scl_oe(scl_oe), .i_sda_in(sda_line), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
        .i_rx_primary_present(prim), .i_rx_secondary_present(sec), .i_rx_dual_capable(dcap),
        .i_rx_legacy(leg), .i_pclk_mhz(pclk), .o_link_mode(mode), .o_primary_tx_en(pri_en),
        .o_secondary_tx_en(sec_en), .o_secondary_bc_en(bc_en), .o_pixel_split(split), .o_tx_half_rate(half),
        .o_shared_prot_session(shared), .o_second_prot_core_en(core2), .o_rate_ok(rate_ok),
        .o_pll_reset(pll), .o_display_id_select(dsel), .o_aux_audio(aux), .o_external_control_bit(ext),
        .o_cable_type_bit(cable), .o_remote_display_id_load(rem), .o_bus_address(baddr));
    ////////////////////////////////////////////////////////////////
    // Bus helpers, all changes at the falling edge
    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_m = b;
        tick(2);
        scl_m = 1'b1;
        tick(2);
        s = sda_line;
        tick(1);
        scl_m = 1'b0;
        tick(2);
    endtask
    task automatic bus_start;
        sda_m = 1'b1;
        scl_m = 1'b1;
        tick(2);
        sda_m = 1'b0;
        tick(3);
        scl_m = 1'b0;
        tick(2);
    endtask
    task automatic bus_stop;
        sda_m = 1'b0;
        tick(2);
        scl_m = 1'b1;
        tick(3);
        sda_m = 1'b1;
        tick(4);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ak);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, s);
        ak = ~s;
    endtask
    task automatic acc(input logic [6:0] a, input logic rd, input logic [7:0] off, input logic [7:0] wd,
        output logic [7:0] q, output logic ak);
        logic [7:0] j;
        logic k;
        bus_start;
        xfer({a, 1'b0}, j, ak);
        xfer(off, j, k);
        if (!rd) xfer(wd, j, k);
        else begin
            bus_stop;
            bus_start;
            xfer({a, 1'b1}, j, k);
            xfer(8'hff, q, k);
        end
        bus_stop;
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        acc(7'h12, 1'b0, off, d, rdat, ack);
    endtask
    task automatic rd(input logic [7:0] off, input logic [7:0] exp, input string what);
        acc(7'h12, 1'b1, off, 8'h00, rdat, ack);
        chk(what, exp, rdat);
    endtask
    task automatic watch;
        seen = 1'b0;
        repeat (6) begin
            tick(1);
            seen = seen | pll;
        end
    endtask
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (40000) @(posedge i_clock);
        bad_count++;
        $display("ERROR timeout expected done seen running");
        stop_test;
    end
    // Main sequence
    initial begin
        tick(3);
        i_resetn = 1'b1;
        tick(5);
        st1 = 2'h0;
        st2 = 3'h0;
        sta = 3'h0;
        tick(3);
        chk("display_id", 8'h01, 8'(dsel));
        chk("aux_audio", 8'h00, 8'(aux));
        chk("external_controller_override", 8'h01, 8'(ext));
        chk("cable", 8'h00, 8'(cable));
        chk("remote_load", 8'h01, 8'(rem));
        chk("bus_addr", 8'h12, 8'(baddr));
        rd(8'h4f, 8'h01, "bridge_control");
        rd(8'h54, 8'ha0, "bridge_configuration");
        rd(8'h5b, 8'h20, "dual_link_control");
        rd(8'h60, 8'h00, "unmapped");
        acc(7'h1a, 1'b0, 8'h4f, 8'h00, rdat, ack);
        chk("foreign_ack", 8'h00, 8'(ack));
        chk("display_id_kept", 8'h01, 8'(dsel));
        $display("test straps done");
        wr(8'h54, 8'h02);
        wr(8'h4f, 8'h00);
        tick(3);
        chk("aux_written", 8'h01, 8'(aux));
        chk("ext_written", 8'h00, 8'(ext));
        chk("remote_written", 8'h00, 8'(rem));
        chk("display_written", 8'h00, 8'(dsel));
        rd(8'h54, 8'h02, "bridge_cfg_back");
        $display("test writes done");
        for (int i = 0; i < 4; i++) begin
            scene = 2'(i);
            watch;
            chk("mode", 8'(em[i]), 8'(mode));
            chk("primary_en", 8'(ep[i]), 8'(pri_en));
            chk("split", 8'(em[i] == 2'h2), 8'(split));
            chk("shared", 8'(em[i] == 2'h2), 8'(shared));
            chk("core2", 8'(em[i] == 2'h3), 8'(core2));
            chk("pll_pulse", 8'(epl[i]), 8'(seen));
        end
        wr(8'h5b, 8'h00);
        scene = 2'h1;
        watch;
        chk("pll_quiet", 8'h00, 8'(seen));
        chk("auto_dual", 8'h02, 8'(mode));
        chk("half_rate", 8'h01, 8'(half));
        chk("rate_dual", 8'h01, 8'(rate_ok));
        $display("test auto modes done");
        wr(8'h5b, 8'h11);
        tick(3);
        chk("forced_single", 8'h01, 8'(mode));
        chk("sec_tx_off", 8'h00, 8'(sec_en));
        chk("sec_bc_off", 8'h00, 8'(bc_en));
        chk("rate_single", 8'h00, 8'(rate_ok));
        scene = 2'h0;
        wr(8'h5b, 8'h92);
        tick(3);
        chk("forced_dual", 8'h02, 8'(mode));
        chk("cable_written", 8'h01, 8'(cable));
        rd(8'h5b, 8'h92, "dual_ctl_back");
        rd(8'h5c, 8'hba, "link_status");
        $display("test forced modes done");
        stop_test;
    end
endmodule // testbench
`default_nettype wire
